/* hw/dmabd_map.vh */
// Constants for the DMA burst and direction engine.
`ifndef DMABD_MAP_VH
`define DMABD_MAP_VH
`define DMABD_DIR_FIXED    2'h0
`define DMABD_DIR_FORWARD  2'h1
`define DMABD_DIR_BACKWARD 2'h2
`define DMABD_SRC_EXT_PIN  4'h1
`define DMABD_ADDR_W       24
`define DMABD_CNT_W        16
`define DMABD_DATA_W       16
`define DMABD_FIFO_DEPTH   8
`define DMABD_FIFO_AW      3
`define DMABD_ST_IDLE      3'h0
`define DMABD_ST_XFER      3'h1
`define DMABD_ST_SAMPLE    3'h2
`define DMABD_ST_YIELD     3'h3
`define DMABD_ST_PAUSE     3'h4
`define DMABD_ST_RELEASE   3'h5
`endif

/* hw/dmabd_fifo.v */
// Parameterised valid/ready FIFO for the engine's data path.
`timescale 1ns/1ps
module dmabd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_clk,
    input  wire             i_reset_n,
    input  wire [WIDTH-1:0] i_wr_data,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    output wire [WIDTH-1:0] o_rd_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wp_q;
    reg [AW:0]      rp_q;
    wire            full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire            empty = (wp_q == rp_q);
    assign o_wr_ready = ~full;
    assign o_rd_valid = ~empty;
    assign o_rd_data  = mem[rp_q[AW-1:0]];
    always @(posedge i_clk) begin
        if (i_wr_valid && !full) begin
            mem[wp_q[AW-1:0]] <= i_wr_data;
        end
    end
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end else begin
            if (i_wr_valid && !full) begin
                wp_q <= wp_q + 1'b1;
            end
            if (i_rd_ready && !empty) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule // dmabd_fifo

/* hw/dmabd_engine.v */
// Burst-mode DMA channel engine with memory address stepping.
`timescale 1ns/1ps
`include "dmabd_map.vh"
// What this block does and what software must do
// R1: Memory address direction selectable as fixed, forward or backward per transfer.
// R2: Forward adds unit size, backward subtracts it, fixed holds the address.
// R3: Software avoids 16-bit bus, 16-bit unit, fixed/forward, odd start.
// R4: Software avoids 16-bit bus, 16-bit unit, backward, even start.
// R5: Software avoids 16-bit DRAM-area backward transfers with odd start.
// R6: Software avoids 16-bit units on an 8-bit external bus.
// R7: Mode bit 0 selects burst; sense bit picks edge (0) or level (1).
// R8: Edge burst accepts any request source of the channel.
// R9: Accepted edge burst moves the whole block without releasing the bus.
// R10: All DMA requests are ignored while a burst is in progress.
// R11: After each unit but the last, refresh or hold requests are granted directly.
// R12: Block end releases the bus; next request sampled after CPU return.
// R13: Software sets request source to external pin in level mode.
// R14: Level mode request flag follows the pin: set when low, clear high.
// R15: Level burst starts when pin is low and the channel is enabled.
// R16: Pin rising mid-burst finishes the current unit then releases the bus.
// R17: Pin falling again resumes at the next address.
// R18: Started level burst accepts no other request until it ends.
// R19: Edge request flag clears only at block end or forced stop.
// R20: Interrupts stay unaccepted during an edge burst until it ends.
module dmabd_engine (
    input  wire        i_clk,
    input  wire        i_reset_n,
    input  wire        i_enable,
    input  wire        i_mode_select,
    input  wire        i_sense_select,
    input  wire [1:0]  i_mem_dir,
    input  wire        i_unit_16,
    input  wire [3:0]  i_req_source_sel,
    input  wire [23:0] i_mem_start,
    input  wire [15:0] i_unit_count,
    input  wire        i_edge_req,
    input  wire        i_ext_transfer_request_pin_n,
    input  wire        i_other_req,
    input  wire        i_refresh_req,
    input  wire        i_hold_req,
    input  wire        i_unit_done,
    input  wire [15:0] i_rd_data,
    input  wire        i_sink_ready,
    output reg         o_bus_own,
    output reg         o_unit_go,
    output reg  [23:0] o_mem_addr,
    output reg         o_grant_other,
    output reg         o_grant_refresh,
    output reg         o_grant_hold,
    output reg         o_req_flag,
    output reg         o_irq_block,
    output reg         o_block_done,
    output reg  [15:0] o_remaining,
    output reg  [15:0] o_wr_data,
    output reg         o_wr_valid
);
    // ************************************************************
    // Decode and state
    // ************************************************************
    reg  [2:0]  state_q;
    reg  [23:0] addr_q;
    reg  [15:0] cnt_q;
    reg         cpu_seen_q;
    reg         ext_low_q;
    reg         level_run_q;
    wire        burst_mode = ~i_mode_select;                     // R7
    wire        level_mode = burst_mode & i_sense_select;        // R7
    wire        edge_mode  = burst_mode & ~i_sense_select;       // R7
    wire        pin_low    = ~i_ext_transfer_request_pin_n;
    wire        ext_src_ok = (i_req_source_sel == `DMABD_SRC_EXT_PIN);
    wire        busy       = (state_q != `DMABD_ST_IDLE);
    wire [23:0] step       = i_unit_16 ? 24'h000002 : 24'h000001;
    reg  [23:0] next_addr;
    wire        fifo_wr_ready;
    wire [15:0] fifo_rd_data;
    wire        fifo_rd_valid;
    wire        fifo_rd_ready = ~o_wr_valid | i_sink_ready;

    always @* begin
        case (i_mem_dir)                                          // R1
            `DMABD_DIR_FORWARD:  next_addr = addr_q + step;       // R2
            `DMABD_DIR_BACKWARD: next_addr = addr_q - step;       // R2
            default:             next_addr = addr_q;              // R2
        endcase
    end

    dmabd_fifo #(
        .WIDTH (`DMABD_DATA_W),
        .DEPTH (`DMABD_FIFO_DEPTH),
        .AW    (`DMABD_FIFO_AW)
    ) u_fifo (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_wr_data  (i_rd_data),
        .i_wr_valid (i_unit_done && state_q == `DMABD_ST_XFER),
        .o_wr_ready (fifo_wr_ready),
        .o_rd_data  (fifo_rd_data),
        .o_rd_valid (fifo_rd_valid),
        .i_rd_ready (fifo_rd_ready)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q         <= `DMABD_ST_IDLE;
            addr_q          <= 24'h000000;
            cnt_q           <= 16'h0000;
            cpu_seen_q      <= 1'b1;
            ext_low_q       <= 1'b0;
            level_run_q     <= 1'b0;
            o_bus_own       <= 1'b0;
            o_unit_go       <= 1'b0;
            o_mem_addr      <= 24'h000000;
            o_grant_other   <= 1'b0;
            o_grant_refresh <= 1'b0;
            o_grant_hold    <= 1'b0;
            o_req_flag      <= 1'b0;
            o_irq_block     <= 1'b0;
            o_block_done    <= 1'b0;
            o_remaining     <= 16'h0000;
            o_wr_data       <= 16'h0000;
            o_wr_valid      <= 1'b0;
        end else begin
            o_unit_go       <= 1'b0;
            o_block_done    <= 1'b0;
            o_grant_refresh <= 1'b0;
            o_grant_hold    <= 1'b0;
            o_grant_other   <= 1'b0;
            ext_low_q       <= pin_low;
            if (fifo_rd_ready) begin
                o_wr_valid <= fifo_rd_valid;
                o_wr_data  <= fifo_rd_data;
            end
            if (level_mode) begin
                o_req_flag <= pin_low;                            // R14
            end
            case (state_q)
                `DMABD_ST_IDLE: begin
                    o_bus_own   <= 1'b0;
                    o_irq_block <= 1'b0;
                    cpu_seen_q  <= 1'b1;
                    if (edge_mode && i_edge_req) begin
                        o_req_flag <= 1'b1;                       // R8
                    end
                    if (!i_enable || !burst_mode || i_unit_count == 16'h0000) begin
                        o_grant_other <= i_other_req;
                    end else if (cpu_seen_q && edge_mode && (i_edge_req || o_req_flag)) begin
                        state_q     <= `DMABD_ST_XFER;            // R9
                        o_bus_own   <= 1'b1;
                        o_irq_block <= 1'b1;                      // R20
                        o_unit_go   <= 1'b1;
                        addr_q      <= i_mem_start;
                        o_mem_addr  <= i_mem_start;
                        cnt_q       <= i_unit_count;
                        o_remaining <= i_unit_count;
                    end else if (cpu_seen_q && level_mode && ext_src_ok && pin_low) begin
                        state_q     <= `DMABD_ST_XFER;            // R15
                        level_run_q <= 1'b1;
                        o_bus_own   <= 1'b1;
                        o_unit_go   <= 1'b1;
                        addr_q      <= i_mem_start;
                        o_mem_addr  <= i_mem_start;
                        cnt_q       <= i_unit_count;
                        o_remaining <= i_unit_count;
                    end else begin
                        o_grant_other <= i_other_req;
                    end
                end
                `DMABD_ST_XFER: begin
                    if (!i_enable) begin
                        state_q <= `DMABD_ST_RELEASE;             // R19
                    end else if (i_unit_done && fifo_wr_ready) begin
                        addr_q      <= next_addr;                 // R1
                        o_mem_addr  <= next_addr;
                        cnt_q       <= cnt_q - 16'h0001;
                        o_remaining <= cnt_q - 16'h0001;
                        state_q     <= `DMABD_ST_SAMPLE;          // R11
                    end
                end
                `DMABD_ST_SAMPLE: begin
                    if (cnt_q == 16'h0000) begin
                        state_q <= `DMABD_ST_RELEASE;             // R12
                    end else if (i_refresh_req || i_hold_req) begin
                        o_grant_refresh <= i_refresh_req;         // R11
                        o_grant_hold    <= i_hold_req & ~i_refresh_req;
                        state_q         <= `DMABD_ST_YIELD;
                    end else if (level_run_q && !ext_low_q) begin
                        o_bus_own <= 1'b0;                        // R16
                        state_q   <= `DMABD_ST_PAUSE;
                    end else begin
                        o_unit_go <= 1'b1;                        // R10
                        state_q   <= `DMABD_ST_XFER;
                    end
                end
                `DMABD_ST_YIELD: begin
                    if (!i_refresh_req && !i_hold_req) begin
                        state_q <= `DMABD_ST_SAMPLE;              // R11
                    end
                end
                `DMABD_ST_PAUSE: begin
                    if (!i_enable) begin
                        state_q <= `DMABD_ST_RELEASE;             // R18
                    end else if (pin_low) begin
                        o_bus_own <= 1'b1;                        // R17
                        o_unit_go <= 1'b1;
                        state_q   <= `DMABD_ST_XFER;
                    end
                end
                `DMABD_ST_RELEASE: begin
                    o_bus_own    <= 1'b0;                         // R12
                    o_irq_block  <= 1'b0;
                    o_block_done <= (cnt_q == 16'h0000);
                    level_run_q  <= 1'b0;
                    cpu_seen_q   <= 1'b0;
                    if (edge_mode) begin
                        o_req_flag <= 1'b0;                       // R19
                    end
                    state_q <= `DMABD_ST_IDLE;
                end
                default: begin
                    state_q <= `DMABD_ST_IDLE;
                end
            endcase
            if (busy && state_q != `DMABD_ST_RELEASE) begin
                cpu_seen_q <= 1'b0;
            end
        end
    end
endmodule // dmabd_engine

/* tb/dmabd_mem_model.sv */
// Memory and I/O model that answers each unit the engine starts.
`timescale 1ns/1ps
module dmabd_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_unit_go,
    input  wire logic [23:0] i_mem_addr,
    input  wire logic [3:0]  i_delay,
    output logic             o_unit_done = 1'b0,
    output logic [15:0]      o_rd_data = 16'h0
);
    logic [3:0] cnt_q = 4'h0;
    always @(posedge i_clk) begin
        o_unit_done <= 1'b0;
        // A released bus shows the inverse of its last value.
        o_rd_data <= ~o_rd_data;
        if (i_unit_go) cnt_q <= i_delay;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
            o_unit_done <= 1'b1;
            o_rd_data <= i_mem_addr[15:0] ^ 16'h5a5a;
        end
    end
endmodule // dmabd_mem_model

/* tb/dmabd_engine_monitor.sv */
// Concurrent checks on the ports of the burst and direction engine.
`timescale 1ns/1ps
`include "dmabd_map.vh"
module dmabd_engine_monitor (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_enable,
    input wire logic        i_sense_select,
    input wire logic [1:0]  i_mem_dir,
    input wire logic        i_unit_16,
    input wire logic        i_refresh_req,
    input wire logic        o_bus_own,
    input wire logic        o_unit_go,
    input wire logic [23:0] o_mem_addr,
    input wire logic        o_grant_other,
    input wire logic        o_grant_refresh,
    input wire logic        o_req_flag,
    input wire logic        o_irq_block,
    input wire logic        o_block_done,
    input wire logic [15:0] o_remaining
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire [23:0] step = i_unit_16 ? 24'h2 : 24'h1;
    sequence unit_taken;
        $past(o_bus_own) && o_remaining == $past(o_remaining) - 16'h1;
    endsequence
    unit_go_pulse_a: assert property (o_unit_go |=> !o_unit_go)
        else $error("unit start longer than one cycle");
    fwd_step_a: assert property (unit_taken ##0 i_mem_dir == `DMABD_DIR_FORWARD
        |-> o_mem_addr == $past(o_mem_addr) + step) else $error("forward step wrong");
    back_step_a: assert property (unit_taken ##0 i_mem_dir == `DMABD_DIR_BACKWARD
        |-> o_mem_addr == $past(o_mem_addr) - step) else $error("backward step wrong");
    fixed_hold_a: assert property (unit_taken ##0 i_mem_dir[0] == i_mem_dir[1]
        |-> $stable(o_mem_addr)) else $error("fixed address moved");
    done_release_a: assert property (o_block_done
        |-> !o_bus_own && (i_sense_select || !o_req_flag) && o_remaining == 16'h0)
        else $error("bad block end");
    burst_kept_a: assert property ($fell(o_bus_own) && !i_sense_select
        |-> o_block_done || !i_enable) else $error("bus dropped inside edge burst");
    other_blocked_a: assert property (o_bus_own |-> !o_grant_other)
        else $error("other channel granted in burst");
    irq_held_a: assert property (o_bus_own && !i_sense_select |-> o_irq_block)
        else $error("interrupts open in edge burst");
    refresh_grant_a: assert property ($rose(i_refresh_req) && o_bus_own && o_remaining > 16'h1
        |-> ##[1:40] o_grant_refresh) else $error("refresh not granted");
endmodule // dmabd_engine_monitor
bind dmabd_engine dmabd_engine_monitor mon (.*);

/* tb/dmabd_engine_tb_top.sv */
// Self-checking bench for the burst and direction engine.
`timescale 1ns/1ps
module dmabd_engine_tb_top;
    logic        i_clk = 0, i_reset_n = 0, i_enable = 1, i_mode_select = 0, i_unit_16 = 0;
    logic        i_sense_select = 0, i_edge_req = 0, i_ext_transfer_request_pin_n = 1;
    logic        i_other_req = 0, i_refresh_req = 0, i_hold_req = 0, i_sink_ready = 1;
    logic [1:0]  i_mem_dir = 0;
    logic [3:0]  i_req_source_sel = 4'h1, dly = 4'h1;
    logic [23:0] i_mem_start = 0, o_mem_addr, ex, dv;
    logic [15:0] i_unit_count = 0, i_rd_data, o_remaining, o_wr_data;
    logic        i_unit_done, o_bus_own, o_unit_go, o_grant_other, o_grant_refresh;
    logic        o_grant_hold, o_req_flag, o_irq_block, o_block_done, o_wr_valid;
    logic [23:0] ga[$];
    logic [15:0] eq[$];
    int          err_total = 0, tests_run = 0, gcnt = 0, dcnt = 0, g0, j, k;
    // Legal setups only: dir, 16-bit unit, start, count, last address.
    logic [66:0] rows[7] = '{
        {2'h1, 1'b0, 24'h000100, 16'h3, 24'h000102}, {2'h1, 1'b1, 24'h000200, 16'h3, 24'h000204},
        {2'h2, 1'b0, 24'h000300, 16'h3, 24'h0002fe}, {2'h2, 1'b1, 24'h000401, 16'h3, 24'h0003fd},
        {2'h0, 1'b1, 24'h000500, 16'h2, 24'h000500}, {2'h3, 1'b0, 24'h000601, 16'h2, 24'h000601},
        {2'h1, 1'b0, 24'h000700, 16'h1, 24'h000700}};
    dmabd_engine DUT (.*);
    dmabd_mem_model mem (.i_clk(i_clk), .i_unit_go(o_unit_go), .i_mem_addr(o_mem_addr),
        .i_delay(dly), .o_unit_done(i_unit_done), .o_rd_data(i_rd_data));
    initial forever #4 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    always @(posedge i_clk) begin
        gcnt <= gcnt + o_grant_other;
        dcnt <= dcnt + o_block_done;
        if (o_unit_go) ga.push_back(o_mem_addr);
        if (o_unit_go) eq.push_back(o_mem_addr[15:0] ^ 16'h5a5a);
        if (o_wr_valid && i_sink_ready) chk(o_wr_data, eq.pop_front(), "data");
    end
    task automatic go(input logic [1:0] d, input logic u, input logic [23:0] s,
                      input logic [15:0] n);
        @(negedge i_clk);
        {i_mem_dir, i_unit_16, i_mem_start, i_unit_count} = {d, u, s, n};
        i_edge_req = !i_sense_select;
        ga.delete();
        @(negedge i_clk);
        i_edge_req = 0;
    endtask
    task automatic fin(input logic [23:0] last);
        for (j = 0; j < 500 && o_block_done !== 1'b1; j++) @(negedge i_clk);
        chk(o_block_done, 1, "block done");
        chk(o_bus_own, 0, "bus owned");
        chk(o_req_flag, 0, "request flag");
        chk(ga[ga.size()-1], last, "last address");
        repeat (3) @(negedge i_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (12) @(negedge i_clk);
        chk(o_mem_addr, 0, "reset address");
        chk({o_bus_own, o_remaining}, 0, "reset outputs");
        i_reset_n = 1;
        foreach (rows[r]) begin
            go(rows[r][66:65], rows[r][64], rows[r][63:40], rows[r][39:24]);
            fin(rows[r][23:0]);
            chk(ga.size(), rows[r][39:24], "unit count");
            dv = rows[r][64] ? 24'h2 : 24'h1;
            for (k = 1; k < ga.size(); k++) begin
                ex = rows[r][66:65] == 2'h1 ? ga[k-1] + dv : rows[r][66:65] == 2'h2 ? ga[k-1] - dv : ga[k-1];
                chk(ga[k], ex, "address step");
            end
        end
        g0 = gcnt;
        dly = 4'h4;
        go(2'h1, 1, 24'h000a00, 16'h4);
        i_other_req = 1;
        @(negedge i_clk);
        i_refresh_req = 1;
        for (j = 0; j < 50 && o_grant_refresh !== 1'b1; j++) @(negedge i_clk);
        chk(o_grant_refresh, 1, "refresh grant");
        i_refresh_req = 0;
        @(negedge i_clk);
        i_hold_req = 1;
        for (j = 0; j < 50 && o_grant_hold !== 1'b1; j++) @(negedge i_clk);
        chk(o_grant_hold, 1, "hold grant");
        i_hold_req = 0;
        i_other_req = 0;
        fin(24'h000a06);
        chk(gcnt, g0, "other grants");
        dly = 4'h1;
        i_sink_ready = 0;
        go(2'h1, 0, 24'h000c00, 16'h8);
        fin(24'h000c07);
        chk(eq.size(), 8, "stalled words");
        i_sink_ready = 1;
        repeat (12) @(negedge i_clk);
        chk(eq.size(), 0, "drained");
        chk(o_wr_valid, 0, "drained valid");
        i_sense_select = 1;
        go(2'h1, 0, 24'h000b00, 16'h3);
        i_ext_transfer_request_pin_n = 0;
        for (j = 0; j < 50 && ga.size() == 0; j++) @(negedge i_clk);
        i_ext_transfer_request_pin_n = 1;
        g0 = gcnt;
        i_other_req = 1;
        repeat (20) @(negedge i_clk);
        i_other_req = 0;
        chk({o_bus_own, o_req_flag}, 0, "paused");
        chk(ga.size(), 1, "paused units");
        chk(gcnt, g0, "grants in pause");
        i_ext_transfer_request_pin_n = 0;
        repeat (2) @(negedge i_clk);
        chk(o_req_flag, 1, "pin low flag");
        for (j = 0; j < 50 && ga.size() < 3; j++) @(negedge i_clk);
        i_ext_transfer_request_pin_n = 1;
        fin(24'h000b02);
        chk(ga[1], 24'h000b01, "resume address");
        i_sense_select = 0;
        i_mode_select = 1;
        go(2'h1, 0, 24'h000d00, 16'h2);
        repeat (4) @(negedge i_clk);
        chk(o_bus_own, 0, "mode one idle");
        i_mode_select = 0;
        g0 = dcnt;
        go(2'h1, 0, 24'h000e00, 16'h8);
        repeat (6) @(negedge i_clk);
        i_enable = 0;
        repeat (6) @(negedge i_clk);
        chk({o_bus_own, o_req_flag, o_irq_block}, 0, "forced stop");
        chk(dcnt, g0, "done on forced stop");
        chk(o_remaining == 16'h0, 0, "remaining on stop");
        print_verdict();
    end
endmodule // dmabd_engine_tb_top
